/* verilog/vcrz_regs.svh */
// Register map and field constants of the VC resource 0 control/status bank.
// Assumes a 32-bit classic Wishbone slave with byte addresses.
`ifndef VCRZ_REGS_SVH
`define VCRZ_REGS_SVH
`define VCRZ_ADDR_W        12
`define VCRZ_OFF_CONTROL   12'h114
`define VCRZ_OFF_STATUS    12'h118
`define VCRZ_OFF_TABLE_LO  12'h120
`define VCRZ_OFF_TABLE_HI  12'h15C
`define VCRZ_SEL_LSB       17
`define VCRZ_SEL_MSB       19
`define VCRZ_LOAD_BIT      16
`define VCRZ_IDENT_LSB     24
`define VCRZ_IDENT_MSB     26
`define VCRZ_ON_BIT        31
`define VCRZ_STALE_BIT     0
`define VCRZ_PEND_BIT      1
`define VCRZ_SEL_RESET     3'h0
`define VCRZ_IDENT_VALUE   3'h0
`define VCRZ_ON_VALUE      1'h1
`define VCRZ_LOAD_CYCLES   4'h4
`endif

/* verilog/vcrz_pkg.sv */
// Types shared by the VC resource 0 register bank.
// Assumes the vcrz_regs.svh constants.
package vcrz_pkg;
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [11:0] adr;
        logic [31:0] dat;
    } vcrz_wb_req_t;

    typedef enum logic [1:0] {
        VCRZ_IDLE = 2'h0,
        VCRZ_LOAD = 2'h1,
        VCRZ_DONE = 2'h3
    } vcrz_load_state_t;
endpackage

/* verilog/vcrz_table_loader.sv */
// Table loader sequencer: on a load command counts LOAD_CYCLES load cycles, then flags done.
// Assumes a single clock and synchronous active-high reset.
`include "vcrz_regs.svh"
module vcrz_table_loader #(
    parameter int LOAD_CYCLES = 4
) (
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic loadStart,
    output logic      loadBusy,
    output logic      loadDone
);
    // Refuse lengths outside 1 to 15 for the four-bit counter
    if (LOAD_CYCLES < 1 || LOAD_CYCLES > 15)
    begin : g_bad_load_cycles
        $error("LOAD_CYCLES out of range");
    end

    vcrz_pkg::vcrz_load_state_t stateReg;
    logic [3:0]                 countReg;

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            stateReg <= vcrz_pkg::VCRZ_IDLE;
            countReg <= 4'h0;
        end
        else
        begin
            case (stateReg)
                vcrz_pkg::VCRZ_IDLE:
                begin
                    if (loadStart)
                    begin
                        stateReg <= vcrz_pkg::VCRZ_LOAD;
                        countReg <= 4'(LOAD_CYCLES - 1);
                    end
                end
                vcrz_pkg::VCRZ_LOAD:
                begin
                    if (countReg == 4'h0)
                        stateReg <= vcrz_pkg::VCRZ_DONE;
                    else
                        countReg <= countReg - 4'h1;
                end
                vcrz_pkg::VCRZ_DONE: stateReg <= vcrz_pkg::VCRZ_IDLE;
                default:             stateReg <= vcrz_pkg::VCRZ_IDLE;
            endcase
        end
    end

    assign loadBusy = (stateReg != vcrz_pkg::VCRZ_IDLE);
    assign loadDone = (stateReg == vcrz_pkg::VCRZ_DONE);
endmodule // vcrz_table_loader

/* verilog/vcrz_bank.sv */
// What this block does
// - Control bits 19:17 hold read-write arbitration select, reset zero
// - Channel identifier bits 26:24 are read-only, always zero
// - Control bit 31 channel enable reads as constant one
// - A table entry write with at least one byte lane enabled sets status bit 0 stale flag
// - Stale flag stays set until load after load command completes
// - Stale flag meaningful only when selected scheme uses the table
// - Status bit 1 reports flow control initialisation in progress
// - Writing one to control bit 16 starts table load unless a load is running; reads zero
//
// Holds the VC resource 0 control/status bank as a classic Wishbone slave.
// Assumes fcInitDone comes from the link layer, synchronous to clk.
`include "vcrz_regs.svh"
module vcrz_bank #(
    parameter int LOAD_CYCLES = 4
) (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [11:0] wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        fcInitDone,
    output logic      [2:0]  arbSchemeSelect,
    output logic             tableLoadPulse
);
    vcrz_pkg::vcrz_wb_req_t req;
    logic [2:0]  arbSelReg;
    logic        staleReg;
    logic        pendReg;
    logic        ackReg;
    logic [31:0] datReg;
    logic        loadPulseReg;
    logic        loadBusy;
    logic        loadDone;
    logic        access;
    logic        wrCtl;
    logic        wrTable;
    logic [31:0] rdData;

    assign req      = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, sel: wb_sel_i,
                        adr: wb_adr_i, dat: wb_dat_i};
    assign access   = req.cyc && req.stb && !ackReg;
    assign wrCtl    = access && req.we && req.adr == `VCRZ_OFF_CONTROL;
    assign wrTable  = access && req.we && req.sel != 4'h0
                      && req.adr >= `VCRZ_OFF_TABLE_LO && req.adr <= `VCRZ_OFF_TABLE_HI;

    vcrz_table_loader #(
        .LOAD_CYCLES (LOAD_CYCLES)
    ) u_loader (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .loadStart (loadPulseReg),
        .loadBusy  (loadBusy),
        .loadDone  (loadDone)
    );

    // Bus answer one cycle after request
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            ackReg <= 1'b0;
        else
            ackReg <= access;
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            arbSelReg <= `VCRZ_SEL_RESET;
        else if (wrCtl && req.sel[2])
            arbSelReg <= req.dat[`VCRZ_SEL_MSB:`VCRZ_SEL_LSB];
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            loadPulseReg <= 1'b0;
        else
            loadPulseReg <= wrCtl && req.sel[2] && req.dat[`VCRZ_LOAD_BIT] && !loadBusy;
    end

    // stale flag, set wins over clear
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            staleReg <= 1'b0;
        else if (wrTable)
            staleReg <= 1'b1;
        else if (loadDone)
            staleReg <= 1'b0;
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            pendReg <= 1'b1;
        else
            pendReg <= !fcInitDone;
    end

    // read mux, load bit reads zero
    always_comb
    begin
        rdData = 32'h0;
        case (req.adr)
            `VCRZ_OFF_CONTROL:
            begin
                rdData[`VCRZ_SEL_MSB:`VCRZ_SEL_LSB]     = arbSelReg;
                rdData[`VCRZ_IDENT_MSB:`VCRZ_IDENT_LSB] = `VCRZ_IDENT_VALUE;
                rdData[`VCRZ_ON_BIT]                    = `VCRZ_ON_VALUE;
            end
            `VCRZ_OFF_STATUS:
            begin
                rdData[`VCRZ_STALE_BIT] = staleReg;
                rdData[`VCRZ_PEND_BIT]  = pendReg;
            end
            default: rdData = 32'h0;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            datReg <= 32'h0;
        else if (access && !req.we)
            datReg <= rdData;
    end

    assign wb_ack_o        = ackReg;
    assign wb_dat_o        = datReg;
    assign arbSchemeSelect = arbSelReg;
    assign tableLoadPulse  = loadPulseReg;

    localparam int LOAD_SPAN = LOAD_CYCLES + 1;

    // Accepted load command on the bus
    sequence seqLoadCmd;
        wrCtl && req.sel[2] && req.dat[`VCRZ_LOAD_BIT] && !loadBusy;
    endsequence

    // Sequencer ends a fixed span after the pulse
    sequence seqLoadFinish;
        ##LOAD_SPAN loadDone;
    endsequence

    chk_table_write_sets: assert property (
        @(posedge clk) disable iff (sys_rst)
        wrTable |=> staleReg)
        else $error("stale flag not set by table write");

    chk_stale_holds: assert property (
        @(posedge clk) disable iff (sys_rst)
        staleReg && !loadDone |=> staleReg)
        else $error("stale flag cleared early");

    chk_load_clears: assert property (
        @(posedge clk) disable iff (sys_rst)
        loadDone && !wrTable |=> !staleReg)
        else $error("stale flag not cleared after load");

    chk_load_starts: assert property (
        @(posedge clk) disable iff (sys_rst)
        seqLoadCmd |=> tableLoadPulse)
        else $error("load command ignored");

    chk_load_finish: assert property (
        @(posedge clk) disable iff (sys_rst)
        tableLoadPulse |-> seqLoadFinish)
        else $error("table load did not finish");

    chk_load_reads_zero: assert property (
        @(posedge clk) disable iff (sys_rst)
        access && !req.we && req.adr == `VCRZ_OFF_CONTROL |=> !wb_dat_o[`VCRZ_LOAD_BIT])
        else $error("load bit not zero on read");

    chk_pend_follows: assert property (
        @(posedge clk) disable iff (sys_rst)
        fcInitDone |=> !pendReg)
        else $error("pending not cleared");

    chk_pend_reset: assert property (
        @(posedge clk)
        sys_rst |=> pendReg)
        else $error("pending not set after reset");

    chk_ctl_read_on: assert property (
        @(posedge clk) disable iff (sys_rst)
        access && !req.we && req.adr == `VCRZ_OFF_CONTROL
        |=> wb_dat_o[`VCRZ_ON_BIT] == `VCRZ_ON_VALUE && wb_ack_o)
        else $error("enable bit not one");

    chk_sel_write: assert property (
        @(posedge clk) disable iff (sys_rst)
        wrCtl && req.sel[2]
        |=> arbSchemeSelect == $past(req.dat[`VCRZ_SEL_MSB:`VCRZ_SEL_LSB]))
        else $error("select not stored");

    chk_sel_guarded: assert property (
        @(posedge clk) disable iff (sys_rst)
        wrCtl && !req.sel[2] |=> $stable(arbSchemeSelect))
        else $error("select changed by masked write");

    chk_sel_reset: assert property (
        @(posedge clk)
        sys_rst |=> arbSchemeSelect == `VCRZ_SEL_RESET)
        else $error("select not cleared by reset");

    chk_ident_zero: assert property (
        @(posedge clk) disable iff (sys_rst)
        wb_ack_o |-> wb_dat_o[`VCRZ_IDENT_MSB:`VCRZ_IDENT_LSB] == `VCRZ_IDENT_VALUE)
        else $error("ident not zero");
endmodule // vcrz_bank

/* sim/test_vcrz_bank.sv */
// Self-checking bench for the VC resource 0 register bank.
// Assumes a classic Wishbone slave answering within a few cycles.
`include "vcrz_regs.svh"
module test_vcrz_bank;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int       LOADN = 8;
    localparam logic [31:0] MASKC = 32'h870F0000;
    localparam logic [7:0]  ARB_CAPS = 8'hFF;
    logic                clk = 1'b0;
    logic                sysRst = 1'b1;
    logic                cyc = 1'b0;
    logic                stb = 1'b0;
    logic                we = 1'b0;
    logic                fcDone = 1'b0;
    logic [3:0]          sel = 4'hF;
    logic [11:0]         adr = 12'h000;
    logic [31:0]         datW = 32'h0;
    logic [31:0]         datR;
    logic [31:0]         rd;
    logic                ack;
    logic                loadPulse;
    logic [2:0]          arbSel;
    int                  errTotal = 0;
    int                  totalChecks = 0;
    int                  pulses = 0;

    always #2 clk = ~clk;
    always @(posedge clk) if (loadPulse === 1'b1) pulses <= pulses + 1;

    vcrz_bank #(.LOAD_CYCLES(LOADN)) dut (
        .clk(clk), .sys_rst(sysRst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_sel_i(sel), .wb_adr_i(adr), .wb_dat_i(datW), .wb_dat_o(datR), .wb_ack_o(ack),
        .fcInitDone(fcDone), .arbSchemeSelect(arbSel), .tableLoadPulse(loadPulse)
    );

    task chk(input logic [31:0] got, input logic [31:0] exp);
        totalChecks++;
        if (got !== exp)
        begin
            errTotal++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task stop_test;
        $display("checks=%0d errors=%0d", totalChecks, errTotal);
        if (errTotal == 0 && totalChecks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // One classic cycle; read data lands in rd
    task access(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        datW <= d;
        // Wait for the answer; only the watchdog ends a hang
        do
            @(posedge clk);
        while (ack !== 1'b1);
        rd = datR;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task t_reset;
        access(1'b0, `VCRZ_OFF_CONTROL, 32'h0);
        chk(rd & MASKC, 32'h80000000);
        access(1'b0, `VCRZ_OFF_STATUS, 32'h0);
        chk(rd & 32'h3, 32'h2);
    endtask

    task t_select;
        int p;
        p = pulses;
        for (int i = 0; i < 8; i++)
        begin
            if (ARB_CAPS[i])
            begin
                access(1'b1, `VCRZ_OFF_CONTROL, 32'h07000000 | (i << 17));
                access(1'b0, `VCRZ_OFF_CONTROL, 32'h0);
                chk(rd & MASKC, 32'h80000000 | (i << 17));
                chk({29'h0, arbSel}, i);
            end
        end
        chk(pulses - p, 32'h0);
    endtask

    task t_load;
        int p;
        access(1'b1, `VCRZ_OFF_TABLE_HI, 32'h1);
        access(1'b0, `VCRZ_OFF_STATUS, 32'h0);
        chk(rd & 32'h1, 32'h1);
        p = pulses;
        access(1'b1, `VCRZ_OFF_CONTROL, 32'h000B0000);
        access(1'b0, `VCRZ_OFF_STATUS, 32'h0);
        chk(rd & 32'h1, 32'h1);
        chk(pulses - p, 32'h1);
        access(1'b0, `VCRZ_OFF_CONTROL, 32'h0);
        chk(rd & MASKC, 32'h800A0000);
        repeat (LOADN + 2) @(posedge clk);
        access(1'b0, `VCRZ_OFF_STATUS, 32'h0);
        chk(rd & 32'h1, 32'h0);
    endtask

    task t_misc;
        int p;
        access(1'b1, 12'h200, 32'hFFFFFFFF);
        access(1'b0, 12'h200, 32'h0);
        chk(rd, 32'h0);
        p = pulses;
        sel <= 4'hB;
        access(1'b1, `VCRZ_OFF_CONTROL, 32'h000F0000);
        sel <= 4'hF;
        access(1'b0, `VCRZ_OFF_CONTROL, 32'h0);
        chk(rd & MASKC, 32'h800A0000);
        chk(pulses - p, 32'h0);
        @(posedge clk);
        fcDone <= 1'b1;
        repeat (3) @(posedge clk);
        access(1'b0, `VCRZ_OFF_STATUS, 32'h0);
        chk(rd & 32'h2, 32'h0);
    endtask

    initial
    begin
        repeat (8) @(posedge clk);
        sysRst <= 1'b0;
        t_reset();
        t_select();
        t_load();
        t_misc();
        stop_test();
    end

    initial
    begin
        repeat (5000) @(posedge clk);
        errTotal++;
        stop_test();
    end
endmodule // test_vcrz_bank
